/* File: hw/pwm_pkg.sv */
// Shared constants, types and register map of the four-channel pulse-width modulator
package pwm_pkg;
    localparam int NUM_CH = 4;
    localparam int DATA_W = 32;
    // Register indices; byte address on the bus is four times the index
    localparam logic [11:0] IDX_ENABLE = 12'h780;
    localparam logic [11:0] IDX_MODE = 12'h782;
    localparam logic [11:0] IDX_POLARITY = 12'h785;
    localparam logic [11:0] IDX_PHASE0 = 12'h788;
    localparam logic [11:0] IDX_COMPARE0 = 12'h794;
    localparam logic [11:0] IDX_GROUPCOUNT = 12'h7ac;
    localparam logic [11:0] IDX_MASK = 12'h7b0;
    localparam logic [11:0] IDX_STATUS = 12'h7b1;
    localparam logic [11:0] IDX_COUNT0 = 12'h7b4;
    localparam logic [11:0] IDX_FRAMES0 = 12'h7c0;
    localparam logic [11:0] STRIDE_PHASE = 12'h002;
    localparam logic [11:0] STRIDE_TIMING = 12'h004;
    localparam logic [11:0] OFFS_CYCLE = 12'h002;
    localparam logic [11:0] STRIDE_COUNT = 12'h002;
    // Field layout
    localparam int STAT_GROUP = 0;
    localparam int STAT_FRAME0 = 2;
    localparam logic [7:0] STAT_VALID = 8'h3d;
    localparam logic [1:0] MODE_CONT = 2'h0;
    localparam logic [1:0] MODE_COUNT = 2'h1;
    // Reset values and bus codes
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;

    typedef enum logic [1:0] {
        CH_IDLE = 2'b00,
        CH_DELAY = 2'b01,
        CH_FRAME = 2'b10
    } chState_e;

    typedef struct packed {
        logic [15:0] phase;
        logic [15:0] compareLength;
        logic [15:0] cycleLength;
    } chanCfg_s;

    typedef struct packed {
        logic [15:0] compareLength;
        logic [15:0] cycleLength;
    } frameLen_s;
endpackage : pwm_pkg

/* File: hw/four_channel_pwm.sv */
// Four-channel pulse-width modulator with AHB-Lite register slave and interrupt
// Operation
// - Polarity clear: output high in compare part, low in remainder part.
// - Polarity set: output low in compare part, high in remainder part.
// - Channel 0 has continuous and counting modes; channels 1-3 continuous only.
// - Channel 0 mode comes from the two-bit mode field.
// - Continuous mode sends frames back to back while enabled.
// - Software clears enable to stop; output drops low at once.
// - Compare and cycle writes take effect from the next frame.
// - Every frame end raises that channel's frame-done request when unmasked.
// - Counting mode sends exactly the programmed group count of frames, one frame for a count of 0.
// - Group end clears channel 0 enable by hardware, unless software writes enable in the same cycle.
// - Group end raises the group-done request when mask bit 0 set.
// - Five interrupt sources: four frame-done plus group-done.
// - Status bits stay set until software clears them.
// - Enable first waits the phase time in delay, driving low.
// - Counter runs compare part to compare value, remainder to cycle length.
// - Mode code 00 continuous, 01 counting, others reserved.
// - Writing 1 clears a status bit, writing 0 leaves it.
`timescale 1ns/1ps
module four_channel_pwm (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic [pwm_pkg::NUM_CH-1:0] pwmOut,
    output logic irq
);
    localparam int N = pwm_pkg::NUM_CH;

    logic [N-1:0] enable_r, enable_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [N-1:0] polarity_r, polarity_nxt;
    logic [15:0] groupCount_r, groupCount_nxt;
    logic [7:0] mask_r, mask_nxt;
    logic [7:0] status_r, status_nxt;
    pwm_pkg::chanCfg_s cfg_r [N];
    pwm_pkg::chanCfg_s cfg_nxt [N];
    pwm_pkg::chState_e chState_r [N];
    pwm_pkg::chState_e chState_nxt [N];
    logic [15:0] cnt_r [N];
    logic [15:0] cnt_nxt [N];
    pwm_pkg::frameLen_s len_r [N];
    pwm_pkg::frameLen_s len_nxt [N];
    logic [15:0] frames_r, frames_nxt;
    logic [N-1:0] pwmOut_r, pwmOut_nxt;
    logic irq_r, irq_nxt;
    logic wrPend_r, wrPend_nxt;
    logic [11:0] wrIdx_r, wrIdx_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic hreadyout_r;
    logic [N-1:0] frameDone;
    logic groupDone;
    logic addrPhase;
    logic [11:0] addrIdx;
    logic swEnableWrite;
    logic swStatusWrite;

    // Index of a per-channel register
    function automatic logic [11:0] chanIdx(input logic [11:0] base,
                                            input logic [11:0] stride,
                                            input int ch);
        chanIdx = base + 12'(ch) * stride;
    endfunction : chanIdx

    assign addrPhase = hsel && hready && (htrans == pwm_pkg::HTRANS_NONSEQ);
    assign addrIdx = haddr[13:2];
    assign swEnableWrite = wrPend_r && (wrIdx_r == pwm_pkg::IDX_ENABLE);
    assign swStatusWrite = wrPend_r && (wrIdx_r == pwm_pkg::IDX_STATUS);

    // Bus slave: zero wait states, write lands at the end of the data phase
    always_comb begin
        wrPend_nxt = addrPhase && hwrite;
        wrIdx_nxt = addrPhase ? addrIdx : wrIdx_r;
        hrdata_nxt = hrdata_r;
        if (addrPhase && !hwrite) begin
            hrdata_nxt = 32'h0000_0000;
            case (addrIdx)
                pwm_pkg::IDX_ENABLE: hrdata_nxt[N-1:0] = enable_r;
                pwm_pkg::IDX_MODE: hrdata_nxt[1:0] = mode_r;
                pwm_pkg::IDX_POLARITY: hrdata_nxt[N-1:0] = polarity_r;
                pwm_pkg::IDX_GROUPCOUNT: hrdata_nxt[15:0] = groupCount_r;
                pwm_pkg::IDX_MASK: hrdata_nxt[7:0] = mask_r;
                pwm_pkg::IDX_STATUS: hrdata_nxt[7:0] = status_r;
                pwm_pkg::IDX_FRAMES0: hrdata_nxt[15:0] = frames_r;
                default: hrdata_nxt = 32'h0000_0000;
            endcase
            for (int i = 0; i < N; i++) begin
                if (addrIdx == chanIdx(pwm_pkg::IDX_PHASE0, pwm_pkg::STRIDE_PHASE, i)) begin
                    hrdata_nxt[15:0] = cfg_r[i].phase;
                end
                if (addrIdx == chanIdx(pwm_pkg::IDX_COMPARE0, pwm_pkg::STRIDE_TIMING, i)) begin
                    hrdata_nxt[15:0] = cfg_r[i].compareLength;
                end
                if (addrIdx == chanIdx(pwm_pkg::IDX_COMPARE0, pwm_pkg::STRIDE_TIMING, i)
                        + pwm_pkg::OFFS_CYCLE) begin
                    hrdata_nxt[15:0] = cfg_r[i].cycleLength;
                end
                if (addrIdx == chanIdx(pwm_pkg::IDX_COUNT0, pwm_pkg::STRIDE_COUNT, i)) begin
                    hrdata_nxt[15:0] = cnt_r[i];
                end
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPend_r <= 1'b0;
            wrIdx_r <= 12'h000;
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b0;
        end else begin
            wrPend_r <= wrPend_nxt;
            wrIdx_r <= wrIdx_nxt;
            hrdata_r <= hrdata_nxt;
            hreadyout_r <= 1'b1;
        end
    end

    // Channel sequencing: idle, delay for the phase time, then frames
    always_comb begin
        logic [16:0] nextCnt;
        logic lastCycle;
        nextCnt = 17'h00000;
        lastCycle = 1'b0;
        frameDone = '0;
        groupDone = 1'b0;
        frames_nxt = frames_r;
        for (int i = 0; i < N; i++) begin
            chState_nxt[i] = chState_r[i];
            cnt_nxt[i] = cnt_r[i];
            len_nxt[i] = len_r[i];
            pwmOut_nxt[i] = 1'b0;
            nextCnt = {1'b0, cnt_r[i]} + 17'h00001;
            if (!enable_r[i]) begin
                chState_nxt[i] = pwm_pkg::CH_IDLE;
                cnt_nxt[i] = 16'h0000;
                if (i == 0) begin
                    frames_nxt = 16'h0000;
                end
            end else begin
                case (chState_r[i])
                    pwm_pkg::CH_IDLE: begin
                        chState_nxt[i] = pwm_pkg::CH_DELAY;
                        cnt_nxt[i] = 16'h0000;
                    end
                    pwm_pkg::CH_DELAY: begin
                        // A zero phase still costs one delay cycle
                        if (nextCnt >= {1'b0, cfg_r[i].phase}) begin
                            chState_nxt[i] = pwm_pkg::CH_FRAME;
                            cnt_nxt[i] = 16'h0000;
                            len_nxt[i].compareLength = cfg_r[i].compareLength;
                            len_nxt[i].cycleLength = cfg_r[i].cycleLength;
                        end else begin
                            cnt_nxt[i] = nextCnt[15:0];
                        end
                    end
                    pwm_pkg::CH_FRAME: begin
                        lastCycle = nextCnt >= {1'b0, len_r[i].cycleLength};
                        if (lastCycle) begin
                            frameDone[i] = 1'b1;
                            cnt_nxt[i] = 16'h0000;
                            // Lengths sampled only at frame boundaries
                            len_nxt[i].compareLength = cfg_r[i].compareLength;
                            len_nxt[i].cycleLength = cfg_r[i].cycleLength;
                            if (i == 0 && mode_r == pwm_pkg::MODE_COUNT) begin
                                frames_nxt = frames_r + 16'h0001;
                                if ({1'b0, frames_r} + 17'h00001 >= {1'b0, groupCount_r}) begin
                                    groupDone = 1'b1;
                                    chState_nxt[i] = pwm_pkg::CH_IDLE;
                                    frames_nxt = 16'h0000;
                                end
                            end
                        end else begin
                            cnt_nxt[i] = nextCnt[15:0];
                        end
                    end
                    default: begin
                        chState_nxt[i] = pwm_pkg::CH_IDLE;
                        cnt_nxt[i] = 16'h0000;
                    end
                endcase
            end
            // Output follows the state being entered, so it stays a pure flop
            if (chState_nxt[i] == pwm_pkg::CH_FRAME && !(i == 0 && groupDone)) begin
                pwmOut_nxt[i] = (cnt_nxt[i] < len_nxt[i].compareLength)
                                ^ polarity_r[i];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < N; i++) begin
                chState_r[i] <= pwm_pkg::CH_IDLE;
                cnt_r[i] <= pwm_pkg::RST_HALF;
                len_r[i] <= '0;
            end
            frames_r <= pwm_pkg::RST_HALF;
            pwmOut_r <= '0;
        end else begin
            for (int i = 0; i < N; i++) begin
                chState_r[i] <= chState_nxt[i];
                cnt_r[i] <= cnt_nxt[i];
                len_r[i] <= len_nxt[i];
            end
            frames_r <= frames_nxt;
            pwmOut_r <= pwmOut_nxt;
        end
    end

    // Software registers, hardware enable clear and sticky status
    always_comb begin
        enable_nxt = enable_r;
        mode_nxt = mode_r;
        polarity_nxt = polarity_r;
        groupCount_nxt = groupCount_r;
        mask_nxt = mask_r;
        status_nxt = status_r;
        for (int i = 0; i < N; i++) begin
            cfg_nxt[i] = cfg_r[i];
        end
        if (groupDone) begin
            enable_nxt[0] = 1'b0;
        end
        if (wrPend_r) begin
            case (wrIdx_r)
                pwm_pkg::IDX_ENABLE: enable_nxt = hwdata[N-1:0];
                pwm_pkg::IDX_MODE: mode_nxt = hwdata[1:0];
                pwm_pkg::IDX_POLARITY: polarity_nxt = hwdata[N-1:0];
                pwm_pkg::IDX_GROUPCOUNT: groupCount_nxt = hwdata[15:0];
                pwm_pkg::IDX_MASK: mask_nxt = hwdata[7:0] & pwm_pkg::STAT_VALID;
                pwm_pkg::IDX_STATUS: status_nxt = status_r & ~hwdata[7:0];
                default: mask_nxt = mask_r;
            endcase
            for (int i = 0; i < N; i++) begin
                if (wrIdx_r == chanIdx(pwm_pkg::IDX_PHASE0, pwm_pkg::STRIDE_PHASE, i)) begin
                    cfg_nxt[i].phase = hwdata[15:0];
                end
                if (wrIdx_r == chanIdx(pwm_pkg::IDX_COMPARE0, pwm_pkg::STRIDE_TIMING, i)) begin
                    cfg_nxt[i].compareLength = hwdata[15:0];
                end
                if (wrIdx_r == chanIdx(pwm_pkg::IDX_COMPARE0, pwm_pkg::STRIDE_TIMING, i)
                        + pwm_pkg::OFFS_CYCLE) begin
                    cfg_nxt[i].cycleLength = hwdata[15:0];
                end
            end
        end
        // Events set after the clear so a same-cycle event is never lost
        for (int i = 0; i < N; i++) begin
            if (frameDone[i]) begin
                status_nxt[pwm_pkg::STAT_FRAME0 + i] = 1'b1;
            end
        end
        if (groupDone) begin
            status_nxt[pwm_pkg::STAT_GROUP] = 1'b1;
        end
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            enable_r <= '0;
            mode_r <= pwm_pkg::MODE_CONT;
            polarity_r <= '0;
            groupCount_r <= pwm_pkg::RST_HALF;
            mask_r <= pwm_pkg::RST_BYTE;
            status_r <= pwm_pkg::RST_BYTE;
            irq_r <= 1'b0;
            for (int i = 0; i < N; i++) begin
                cfg_r[i] <= '0;
            end
        end else begin
            enable_r <= enable_nxt;
            mode_r <= mode_nxt;
            polarity_r <= polarity_nxt;
            groupCount_r <= groupCount_nxt;
            mask_r <= mask_nxt;
            status_r <= status_nxt;
            irq_r <= irq_nxt;
            for (int i = 0; i < N; i++) begin
                cfg_r[i] <= cfg_nxt[i];
            end
        end
    end

    assign hreadyout = hreadyout_r;
    assign hresp = pwm_pkg::HRESP_OKAY;
    assign hrdata = hrdata_r;
    assign pwmOut = pwmOut_r;
    assign irq = irq_r;

    a_disable_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        (pwmOut_r & ~$past(enable_r)) == '0)
        else $error("Output high after channel disable");

    a_delay_low: assert property (
        @(posedge clk) disable iff (!rst_n)
        chState_r[1] == pwm_pkg::CH_DELAY |-> !pwmOut_r[1])
        else $error("Output high during delay");

    a_normal_polarity: assert property (
        @(posedge clk) disable iff (!rst_n)
        chState_r[0] == pwm_pkg::CH_FRAME && cnt_r[0] == 16'h0000
        && len_r[0].compareLength != 16'h0000 && !$past(polarity_r[0]) |-> pwmOut_r[0])
        else $error("Compare part not high with polarity clear");

    a_inverted_polarity: assert property (
        @(posedge clk) disable iff (!rst_n)
        chState_r[0] == pwm_pkg::CH_FRAME && cnt_r[0] == 16'h0000
        && len_r[0].compareLength != 16'h0000 && $past(polarity_r[0]) |-> !pwmOut_r[0])
        else $error("Compare part not low with polarity set");

    a_frame_lengths: assert property (
        @(posedge clk) disable iff (!rst_n)
        chState_r[0] == pwm_pkg::CH_FRAME && enable_r[0] && !frameDone[0]
        |=> $stable(len_r[0]))
        else $error("Frame lengths changed mid-frame");

    a_frame_status: assert property (
        @(posedge clk) disable iff (!rst_n)
        frameDone[2] |=> status_r[pwm_pkg::STAT_FRAME0 + 2]
        ##1 (status_r[pwm_pkg::STAT_FRAME0 + 2] || $past(swStatusWrite)))
        else $error("Frame-done status not set");

    a_group_stop: assert property (
        @(posedge clk) disable iff (!rst_n)
        groupDone && !swEnableWrite |=> !enable_r[0] ##1 !pwmOut_r[0])
        else $error("Channel 0 still enabled after group");

    a_group_status: assert property (
        @(posedge clk) disable iff (!rst_n)
        groupDone |=> status_r[pwm_pkg::STAT_GROUP])
        else $error("Group-done status not set");

    a_status_sticky: assert property (
        @(posedge clk) disable iff (!rst_n)
        status_r[0] && !swStatusWrite |=> status_r[0])
        else $error("Status bit lost without clear");

    a_status_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        swStatusWrite && hwdata[pwm_pkg::STAT_GROUP] && !groupDone
        |=> !status_r[pwm_pkg::STAT_GROUP])
        else $error("Write of one did not clear status");

    a_continuous_only: assert property (
        @(posedge clk) disable iff (!rst_n)
        enable_r[3] && !swEnableWrite |=> enable_r[3])
        else $error("Channel 3 stopped by itself");
endmodule : four_channel_pwm

/* File: test/pwm_load.sv */
// Load model on the pulse outputs: tallies the high cycles of each channel
`timescale 1ns/1ps
module pwm_load (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [pwm_pkg::NUM_CH-1:0] pwmOut,
    output logic [pwm_pkg::NUM_CH-1:0][15:0] highCnt
);
    // Counts wrap; only differences over short windows are meaningful
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            highCnt <= '0;
        end else begin
            for (int i = 0; i < pwm_pkg::NUM_CH; i++) begin
                if (pwmOut[i]) begin
                    highCnt[i] <= highCnt[i] + 16'h0001;
                end
            end
        end
    end
endmodule : pwm_load

/* File: test/testbench.sv */
// Self-checking bench for the four-channel pulse-width modulator
`timescale 1ns/1ps
`define CHK(g, e) begin numChecks++; if ((g) !== (e)) begin miscompares++; \
    $display("Error at %0t: got %h expected %h", $time, g, e); end end
module testbench;
    logic clk, rst_n, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, seed, rdat;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [pwm_pkg::NUM_CH-1:0] pwmOut;
    logic [pwm_pkg::NUM_CH-1:0][15:0] highCnt;
    logic [15:0] s0, g;
    int miscompares = 0;
    int numChecks = 0;
    int edgeCnt = 0;
    int t0;
    localparam logic [11:0] REGS [7] = '{pwm_pkg::IDX_ENABLE, pwm_pkg::IDX_MODE,
        pwm_pkg::IDX_POLARITY, pwm_pkg::IDX_GROUPCOUNT, pwm_pkg::IDX_MASK,
        pwm_pkg::IDX_STATUS, 12'h781};
    assign hready = hreadyout;
    four_channel_pwm u_four_channel_pwm (.clk(clk), .rst_n(rst_n), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .pwmOut(pwmOut), .irq(irq));
    pwm_load u_pwm_load (.clk(clk), .rst_n(rst_n), .pwmOut(pwmOut), .highCnt(highCnt));
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) edgeCnt <= edgeCnt + 1;
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    // High cycles over n whole frames; a compare longer than the frame fills it
    function automatic logic [15:0] exp_high(input logic [15:0] cmp, input logic [15:0] len,
                                             input logic pol, input int n);
        logic [15:0] c;
        c = (cmp > len) ? len : cmp;
        return pol ? 16'(n * (len - c)) : 16'(n * c);
    endfunction : exp_high
    // One single AHB-Lite transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [11:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
        hsel <= 1'b1;
        haddr <= {18'h0, idx, 2'b00};
        htrans <= pwm_pkg::HTRANS_NONSEQ;
        hwrite <= w;
        hsize <= 3'h2;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
        #1;
    endtask : bus
    task automatic wr(input logic [11:0] idx, input logic [31:0] d);
        bus(1'b1, idx, d, rdat);
    endtask : wr
    task automatic chk_rd(input logic [11:0] idx, input logic [31:0] e);
        bus(1'b0, idx, 32'h0, rdat);
        `CHK(rdat, e)
        `CHK(hresp, pwm_pkg::HRESP_OKAY)
    endtask : chk_rd
    task automatic wait_to(input int t);
        while (edgeCnt < t) begin
            @(posedge clk);
            #1;
        end
    endtask : wait_to
    task automatic tick();
        @(posedge clk);
        #1;
    endtask : tick
    // Configure and enable one channel, then count highs over nFr frame slots
    task automatic run(input int ch, input logic [15:0] ph, input logic [15:0] cmp,
                       input logic [15:0] len, input logic pol, input int nFr, input int nExp);
        logic [11:0] b;
        b = 12'(pwm_pkg::IDX_COMPARE0 + pwm_pkg::STRIDE_TIMING * ch);
        wr(12'(pwm_pkg::IDX_PHASE0 + pwm_pkg::STRIDE_PHASE * ch), {16'h0, ph});
        wr(b, {16'h0, cmp});
        wr(12'(b + pwm_pkg::OFFS_CYCLE), {16'h0, len});
        wr(pwm_pkg::IDX_POLARITY, 32'(pol) << ch);
        wr(pwm_pkg::IDX_ENABLE, 32'h1 << ch);
        t0 = edgeCnt;
        s0 = highCnt[ch];
        wait_to(t0 + 1 + ph + nFr * len);
        `CHK(16'(highCnt[ch] - s0), exp_high(cmp, len, pol, nExp))
    endtask : run
    task automatic stop_test();
        if (miscompares == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : stop_test
    initial begin
        seed = 32'd89;
        rst_n = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        repeat (2) @(posedge clk);
        #1;
        // Reset values, then an unmapped place that must drop writes
        for (int i = 0; i < 7; i++) chk_rd(REGS[i], 32'h0);
        wr(12'h781, 32'hff);
        chk_rd(12'h781, 32'h0);
        // Reserved mask bits must not stick
        wr(pwm_pkg::IDX_MASK, 32'hff);
        chk_rd(pwm_pkg::IDX_MASK, {24'h0, pwm_pkg::STAT_VALID});
        wr(pwm_pkg::IDX_MASK, 32'h0);
        // Counting mode selected for 1-3 must not stop them
        for (int ch = 0; ch < pwm_pkg::NUM_CH; ch++) begin
            wr(pwm_pkg::IDX_MODE, (ch == 0) ? 32'h0 : 32'h1);
            run(ch, 16'(rnd() % 4 + 1), 16'(rnd() % 8 + 1), 16'(rnd() % 8 + 2),
                1'(rnd()), 3, 3);
            wr(pwm_pkg::IDX_ENABLE, 32'h0);
            tick();
            `CHK(pwmOut[ch], 1'b0)
            chk_rd(12'(pwm_pkg::IDX_COUNT0 + pwm_pkg::STRIDE_COUNT * ch), 32'h0);
            chk_rd(pwm_pkg::IDX_STATUS, 32'h1 << (pwm_pkg::STAT_FRAME0 + ch));
            `CHK(irq, 1'b0)
            wr(pwm_pkg::IDX_MASK, 32'h1 << (pwm_pkg::STAT_FRAME0 + ch));
            tick();
            `CHK(irq, 1'b1)
            wr(pwm_pkg::IDX_STATUS, 32'h0);
            chk_rd(pwm_pkg::IDX_STATUS, 32'h1 << (pwm_pkg::STAT_FRAME0 + ch));
            wr(pwm_pkg::IDX_STATUS, 32'h1 << (pwm_pkg::STAT_FRAME0 + ch));
            tick();
            `CHK(irq, 1'b0)
            chk_rd(pwm_pkg::IDX_STATUS, 32'h0);
            wr(pwm_pkg::IDX_MASK, 32'h0);
        end
        // Compare rewritten in mid-frame: first frame keeps 2 highs, the next two get 6
        wr(pwm_pkg::IDX_MODE, 32'h0);
        wr(12'(pwm_pkg::IDX_PHASE0 + pwm_pkg::STRIDE_PHASE), 32'h3);
        wr(12'(pwm_pkg::IDX_COMPARE0 + pwm_pkg::STRIDE_TIMING), 32'h2);
        wr(12'(pwm_pkg::IDX_COMPARE0 + pwm_pkg::STRIDE_TIMING + pwm_pkg::OFFS_CYCLE), 32'h9);
        wr(pwm_pkg::IDX_POLARITY, 32'h0);
        wr(pwm_pkg::IDX_ENABLE, 32'h2);
        t0 = edgeCnt;
        s0 = highCnt[1];
        wait_to(t0 + 6);
        wr(12'(pwm_pkg::IDX_COMPARE0 + pwm_pkg::STRIDE_TIMING), 32'h6);
        chk_rd(12'(pwm_pkg::IDX_COMPARE0 + pwm_pkg::STRIDE_TIMING), 32'h6);
        wait_to(t0 + 1 + 3 + 27);
        `CHK(16'(highCnt[1] - s0), 16'd14)
        wr(pwm_pkg::IDX_ENABLE, 32'h0);
        wr(pwm_pkg::IDX_STATUS, 32'hff);
        // Two groups back to back: the second must restart from the delay state
        wr(pwm_pkg::IDX_MODE, {30'h0, pwm_pkg::MODE_COUNT});
        wr(pwm_pkg::IDX_MASK, 32'h1);
        for (int r = 0; r < 2; r++) begin
            g = 16'(rnd() % 4 + 1);
            wr(pwm_pkg::IDX_GROUPCOUNT, {16'h0, g});
            // Alternating polarity so both senses meet a group end
            run(0, 16'(rnd() % 4 + 1), 16'(rnd() % 8 + 1), 16'(rnd() % 8 + 2),
                1'(r), g + 2, g);
            chk_rd(pwm_pkg::IDX_ENABLE, 32'h0);
            chk_rd(pwm_pkg::IDX_FRAMES0, 32'h0);
            chk_rd(pwm_pkg::IDX_STATUS, 32'h5);
            `CHK(irq, 1'b1)
            wr(pwm_pkg::IDX_STATUS, 32'h5);
            tick();
            `CHK(irq, 1'b0)
        end
        stop_test();
    end
    // Whole run needs several hundred cycles; a hang is cut well beyond that
    initial begin
        repeat (20000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule : testbench
